// [verilog/e1p_pkg.sv]
// Shared constants and types for the parallel control port.
package e1p_pkg;

  // ==========================================================================
  // Widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int LOW_ADDR_W = 7;
  localparam int SYNC_STAGES = 2;

  // ==========================================================================
  // Register addresses and reset values
  localparam logic [7:0] ADDR_STATUS1 = 8'h06;
  localparam logic [7:0] ADDR_STATUS2 = 8'h07;
  localparam logic [7:0] ADDR_MASK1 = 8'h16;
  localparam logic [7:0] ADDR_MASK2 = 8'h17;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int RX_LOSS_NS = 2000;
  // Longest allowed gap between receive clock edges, rounded down.
  localparam int RX_LOSS_CYCLES = (RX_LOSS_NS / CLK_PERIOD_NS < 1) ? 1 :
                                  RX_LOSS_NS / CLK_PERIOD_NS;
  localparam logic [7:0] RX_LOSS_CNT = 8'(RX_LOSS_CYCLES);

  // ==========================================================================
  // Access sequencer states
  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_READ,
    ACC_WRITE
  } e1p_acc_t;

  // A strobe pin is active at its level when active_high, else when low.
  function automatic logic strobe_on(input logic pin, input logic active_high);
    strobe_on = active_high ? pin : ~pin;
  endfunction : strobe_on

endpackage : e1p_pkg

// [verilog/e1p_sync.sv]
// Two-stage synchroniser for a bundle of asynchronous pins.
module e1p_sync
  import e1p_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Pins and synchronised copy
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      pin_sync <= '0;
    end
    else
    begin
      meta_q <= pin_in;
      pin_sync <= meta_q;
    end
  end

endmodule : e1p_sync

// [verilog/e1p_regs.sv]
// Register space behind the port, with the two status and mask registers.
module e1p_regs
  import e1p_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Write port
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  // Read port
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data,
  // Condition events from the transceiver
  input wire logic [DATA_W-1:0] status1_set,
  input wire logic [DATA_W-1:0] status2_set,
  // Pending unmasked condition
  output logic irq
);

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] status1_q;
  logic [DATA_W-1:0] status2_q;
  logic [DATA_W-1:0] mask1_q;
  logic [DATA_W-1:0] mask2_q;

  // ==========================================================================
  // Plain storage; its content is undefined until software writes it.
  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  // ==========================================================================
  // Status bits are sticky; writing a one clears a bit, but a new event in
  // the same cycle keeps it set so no condition is lost.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      status1_q <= RESET_BYTE;
      status2_q <= RESET_BYTE;
    end
    else
    begin
      if (wr_en && wr_addr == ADDR_STATUS1)
        status1_q <= (status1_q & ~wr_data) | status1_set;
      else
        status1_q <= status1_q | status1_set;
      if (wr_en && wr_addr == ADDR_STATUS2)
        status2_q <= (status2_q & ~wr_data) | status2_set;
      else
        status2_q <= status2_q | status2_set;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mask1_q <= RESET_BYTE;
      mask2_q <= RESET_BYTE;
    end
    else if (wr_en)
    begin
      if (wr_addr == ADDR_MASK1)
        mask1_q <= wr_data;
      if (wr_addr == ADDR_MASK2)
        mask2_q <= wr_data;
    end
  end

  always_comb
  begin
    case (rd_addr)
      ADDR_STATUS1: rd_data = status1_q;
      ADDR_STATUS2: rd_data = status2_q;
      ADDR_MASK1: rd_data = mask1_q;
      ADDR_MASK2: rd_data = mask2_q;
      default: rd_data = mem[rd_addr];
    endcase
  end

  assign irq = |(status1_q & mask1_q) | |(status2_q & mask2_q);

endmodule : e1p_regs

// [verilog/e1p_port.sv]
// Eight-bit parallel host control port of the E1 transceiver.
// Summary of operation
// - Mode strap picks shared or separate address bus.
// - Shared lines carry address first, then data.
// - Separate mode: seven lines plus latch pin address.
// - Shared mode latches address on strobe rising edge.
// - Style strap picks strobe pair or direction line.
// - Data strobe low in shared, high separate.
// - Accesses only while chip select is low.
// - Low write input marks a write cycle.
// - Open-drain interrupt pulls low on pending unmasked conditions.
// - Tri-state input floats every output pin.
module e1p_port
  import e1p_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Straps and test control
  input wire logic bus_mode_select,
  input wire logic bus_style_select,
  input wire logic tri_state_ctrl,
  // Host strobes
  input wire logic chip_select_n,
  input wire logic read_data_strobe,
  input wire logic write_dir,
  input wire logic addr_strobe,
  // Host address and data
  input wire logic [LOW_ADDR_W-1:0] low_address_lines,
  input wire logic [DATA_W-1:0] shared_addr_data_lines_in,
  output logic [DATA_W-1:0] shared_addr_data_lines_out,
  output logic [DATA_W-1:0] shared_addr_data_lines_oe,
  // Interrupt, open drain
  output logic int_n_out,
  output logic int_n_oe,
  // Receive clock, used only as a presence check
  input wire logic rx_line_clock_in,
  // Condition events
  input wire logic [DATA_W-1:0] status1_set,
  input wire logic [DATA_W-1:0] status2_set
);

  // ==========================================================================
  // Pin synchronisation
  localparam int PIN_W = 8 + LOW_ADDR_W + DATA_W;

  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s;
  logic mux_s;
  logic bts_s;
  logic tri_s;
  logic cs_n_s;
  logic rds_s;
  logic wr_s;
  logic as_s;
  logic rxclk_s;
  logic [LOW_ADDR_W-1:0] low_s;
  logic [DATA_W-1:0] data_s;

  assign pins_raw = {bus_mode_select, bus_style_select, tri_state_ctrl,
                     chip_select_n, read_data_strobe, write_dir, addr_strobe,
                     rx_line_clock_in, low_address_lines,
                     shared_addr_data_lines_in};

  // Every host pin crosses two flops before the sequencer looks at it.
  e1p_sync #(.WIDTH(PIN_W)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in(pins_raw),
    .pin_sync(pins_s)
  );

  assign {mux_s, bts_s, tri_s, cs_n_s, rds_s, wr_s, as_s, rxclk_s, low_s,
          data_s} = pins_s;

  // ==========================================================================
  // Strobe decode
  logic cs_act;
  logic rds_act;
  logic read_act;
  logic write_act;

  assign cs_act = ~cs_n_s;
  // The data strobe is high active only in separate mode; read is low.
  assign rds_act = strobe_on(rds_s, bts_s & ~mux_s);
  always_comb
  begin
    if (bts_s)
    begin
      read_act = cs_act & rds_act & wr_s;
      write_act = cs_act & rds_act & ~wr_s;
    end
    else
    begin
      read_act = cs_act & rds_act;
      write_act = cs_act & strobe_on(wr_s, 1'b0);
    end
  end

  // ==========================================================================
  // Receive clock presence
  logic rxclk_d1_q;
  logic [7:0] rx_gap_q;
  logic rx_alive;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rxclk_d1_q <= 1'b0;
    else
      rxclk_d1_q <= rxclk_s;
  end

  // Without the receive clock the port refuses new accesses.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rx_gap_q <= RX_LOSS_CNT;
    else if (rxclk_s != rxclk_d1_q)
      rx_gap_q <= 8'h00;
    else if (rx_gap_q != RX_LOSS_CNT)
      rx_gap_q <= rx_gap_q + 8'h01;
  end

  // The dead state after reset also hides the synchroniser's zero reset
  // values, which would otherwise look like an active chip select.
  assign rx_alive = (rx_gap_q != RX_LOSS_CNT);

  // ==========================================================================
  // Shared-bus address latch
  logic as_d1_q;
  logic [ADDR_W-1:0] mux_addr_q;
  logic as_rise;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      as_d1_q <= 1'b0;
    else
      as_d1_q <= as_s;
  end

  assign as_rise = as_s & ~as_d1_q;

  // Address and strobe are synchronised together, so they stay aligned.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      mux_addr_q <= 8'h00;
    else if (mux_s && as_rise)
      mux_addr_q <= data_s;
  end

  // ==========================================================================
  // Access sequencer
  e1p_acc_t state_q;
  logic [ADDR_W-1:0] acc_addr_q;
  logic [ADDR_W-1:0] acc_addr_d;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] reg_rd_data;
  logic commit;
  logic start;
  logic irq;

  // In shared mode the low address pins are ignored.
  assign acc_addr_d = mux_s ? mux_addr_q : {as_s, low_s};
  assign start = (state_q == ACC_IDLE) && rx_alive && (read_act | write_act);
  // A write lands once, when its strobe ends.
  assign commit = (state_q == ACC_WRITE) && !write_act;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      state_q <= ACC_IDLE;
    else
    begin
      case (state_q)
        ACC_IDLE:
          if (rx_alive && read_act)
            state_q <= ACC_READ;
          else if (rx_alive && write_act)
            state_q <= ACC_WRITE;
        ACC_READ:
          if (!read_act)
            state_q <= ACC_IDLE;
        ACC_WRITE:
          if (!write_act)
            state_q <= ACC_IDLE;
        default:
          state_q <= ACC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      acc_addr_q <= 8'h00;
    else if (start)
      acc_addr_q <= acc_addr_d;
  end

  // Data is taken from the lines every cycle of the strobe after the first.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      wdata_q <= 8'h00;
    else if (state_q == ACC_WRITE && write_act)
      wdata_q <= data_s;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rdata_q <= 8'h00;
    else if (state_q == ACC_READ)
      rdata_q <= reg_rd_data;
  end

  e1p_regs u_regs (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(commit),
    .wr_addr(acc_addr_q),
    .wr_data(wdata_q),
    .rd_addr(acc_addr_q),
    .rd_data(reg_rd_data),
    .status1_set(status1_set),
    .status2_set(status2_set),
    .irq(irq)
  );

  // ==========================================================================
  // Pin drivers
  logic drive_data;

  // The first driven cycle shows the previous byte, so hosts sample late.
  assign drive_data = (state_q == ACC_READ) && read_act && !tri_s;
  assign shared_addr_data_lines_out = rdata_q;
  assign shared_addr_data_lines_oe = {DATA_W{drive_data}};
  assign int_n_out = 1'b0;
  assign int_n_oe = irq & ~tri_s;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  tri_state_a: assert property (tri_s |->
    shared_addr_data_lines_oe == 8'h00 && !int_n_oe)
    else $error("Pins driven while tri-state control is high");

  cs_gate_a: assert property (
    (state_q == ACC_IDLE && !cs_act) |=> state_q == ACC_IDLE)
    else $error("Access started without chip select");

  one_write_a: assert property (commit |=> !commit ##1 !commit)
    else $error("Write committed more than once");

  addr_latch_a: assert property (
    (mux_s && as_rise) |=> mux_addr_q == $past(data_s))
    else $error("Shared address not latched on strobe rise");

  sep_addr_a: assert property (
    (start && !mux_s) |=> acc_addr_q == $past({as_s, low_s}))
    else $error("Separate address not taken from address pins");

  mux_addr_a: assert property (
    (start && mux_s) |=> acc_addr_q == $past(mux_addr_q))
    else $error("Shared mode used the low address pins");

  read_drive_a: assert property (
    $rose(drive_data) |-> $past(read_act))
    else $error("Data lines driven outside a read");

  int_pull_a: assert property (
    irq && !tri_s |-> int_n_oe && !int_n_out)
    else $error("Pending condition not signalled");

  rx_dead_a: assert property (
    (state_q == ACC_IDLE && !rx_alive) |=> state_q == ACC_IDLE)
    else $error("Access accepted without receive clock");

  wr_low_a: assert property (
    (state_q == ACC_IDLE && rx_alive && !bts_s && cs_act && !rds_act &&
     !wr_s) |=> state_q == ACC_WRITE)
    else $error("Low write input did not start a write");

  ds_high_a: assert property (
    (state_q == ACC_IDLE && rx_alive && bts_s && !mux_s && cs_act &&
     rds_s && !wr_s) |=> state_q == ACC_WRITE)
    else $error("High data strobe did not start a write");

  rd_low_a: assert property (
    (state_q == ACC_IDLE && rx_alive && mux_s && cs_act && !rds_s &&
     wr_s) |=> state_q == ACC_READ)
    else $error("Low strobe did not start a shared-bus read");

  read_cov_c: cover property (state_q == ACC_READ ##1 state_q == ACC_IDLE);
  write_cov_c: cover property (commit);
  mux_cov_c: cover property (mux_s && as_rise ##[1:20] commit);
  ds_cov_c: cover property (bts_s && start);
  tri_cov_c: cover property (tri_s && read_act);

endmodule : e1p_port

// [tb/e1p_host.sv]
// Host processor model that runs one register access at a time.
module e1p_host
  import e1p_pkg::*;
(
  // Clock, straps and test control
  input wire logic clk_sys,
  input wire logic bus_mode_select,
  input wire logic bus_style_select,
  input wire logic skip_cs,
  // Resolved data lines
  input wire logic [7:0] bus_level,
  // Host pins
  output logic chip_select_n,
  output logic read_data_strobe,
  output logic write_dir,
  output logic addr_strobe,
  output logic [6:0] low_address_lines,
  output logic [7:0] host_data,
  output logic host_en
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ds_on;
  logic wr_on;
  logic act_hi;

  // ==========================================================================
  // Strobe levels
  // Levels follow the straps at once, so a strap change never fakes a strobe.
  assign act_hi = bus_style_select & ~bus_mode_select;
  assign read_data_strobe = act_hi ? ds_on : ~ds_on;
  assign write_dir = ~wr_on;

  initial
  begin
    chip_select_n = 1'b1;
    ds_on = 1'b0;
    wr_on = 1'b0;
    addr_strobe = 1'b0;
    low_address_lines = 7'h00;
    host_data = 8'h00;
    host_en = 1'b0;
  end

  // ==========================================================================
  // One access
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    #1;
    chip_select_n = skip_cs;
    if (bus_mode_select)
    begin
      low_address_lines = 7'h00;
      host_data = a;
      host_en = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      addr_strobe = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
    end
    else
    begin
      low_address_lines = a[6:0];
      addr_strobe = a[7];
    end
    host_en = wr;
    host_data = d;
    ds_on = bus_style_select | ~wr;
    wr_on = wr;
    repeat (6) @(posedge clk_sys);
    #1;
    q = bus_level;
    chip_select_n = 1'b1;
    ds_on = 1'b0;
    wr_on = 1'b0;
    addr_strobe = 1'b0;
    host_en = 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask : access

endmodule : e1p_host

// [tb/test_e1p_port.sv]
// Self-checking bench for the parallel control port.
module test_e1p_port;
  import e1p_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic mode = 1'b0;
  logic style = 1'b0;
  logic tri_st = 1'b0;
  logic skip_cs = 1'b0;
  logic rx_clk = 1'b0;
  logic rx_run = 1'b1;
  logic [7:0] s1_set = 8'h00;
  logic [7:0] s2_set = 8'h00;
  logic [7:0] float_q = 8'h5a;
  logic [7:0] bus;
  logic [7:0] dout;
  logic [7:0] doe;
  logic [7:0] hdata;
  logic hen;
  logic cs_n;
  logic rds;
  logic wrd;
  logic ast;
  logic [6:0] la;
  logic int_out;
  logic int_oe;
  int oe_cnt = 0;
  logic [7:0] q;
  int mismatches = 0;
  int checks = 0;

  // ==========================================================================
  // Clocks and wire resolution
  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end
  // The receive clock only runs while rx_run is set.
  initial
  begin
    forever #244 rx_clk = rx_run ? ~rx_clk : rx_clk;
  end
  // Undriven lines show a changing pattern rather than a stale value.
  always @(posedge clk_sys) float_q <= ~float_q;
  always @(posedge clk_sys) oe_cnt <= oe_cnt + int'(|doe);
  assign bus = (doe & dout) | (~doe & (hen ? hdata : float_q));

  e1p_host i_host (.clk_sys(clk_sys), .bus_mode_select(mode),
    .bus_style_select(style), .skip_cs(skip_cs), .bus_level(bus),
    .chip_select_n(cs_n), .read_data_strobe(rds), .write_dir(wrd),
    .addr_strobe(ast), .low_address_lines(la), .host_data(hdata),
    .host_en(hen));

  e1p_port i_dut (.clk_sys(clk_sys), .rst(rst), .bus_mode_select(mode),
    .bus_style_select(style), .tri_state_ctrl(tri_st),
    .chip_select_n(cs_n), .read_data_strobe(rds), .write_dir(wrd),
    .addr_strobe(ast), .low_address_lines(la),
    .shared_addr_data_lines_in(bus), .shared_addr_data_lines_out(dout),
    .shared_addr_data_lines_oe(doe), .int_n_out(int_out),
    .int_n_oe(int_oe), .rx_line_clock_in(rx_clk), .status1_set(s1_set),
    .status2_set(s2_set));

  // ==========================================================================
  // Helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  // ==========================================================================
  // Scenarios
  task automatic t_sep_rw;
    i_host.access(1'b1, 8'h85, 8'h3c, q);
    i_host.access(1'b1, 8'h05, 8'hc3, q);
    i_host.access(1'b0, 8'h85, 8'h00, q);
    chk(q, 8'h3c);
    i_host.access(1'b0, 8'h05, 8'h00, q);
    chk(q, 8'hc3);
  endtask : t_sep_rw

  task automatic t_modes;
    logic [1:0] ms [3] = '{2'b10, 2'b11, 2'b01};
    for (int i = 0; i < 3; i++)
    begin
      #1 {mode, style} = ms[i];
      i_host.access(1'b1, 8'hc0 + 8'(i), 8'ha5 ^ 8'(i), q);
      i_host.access(1'b0, 8'hc0 + 8'(i), 8'h00, q);
      chk(q, 8'ha5 ^ 8'(i));
    end
    #1 {mode, style} = 2'b00;
  endtask : t_modes

  task automatic t_cs;
    #1 skip_cs = 1'b1;
    i_host.access(1'b1, 8'h85, 8'hff, q);
    #1 skip_cs = 1'b0;
    i_host.access(1'b0, 8'h85, 8'h00, q);
    chk(q, 8'h3c);
  endtask : t_cs

  task automatic t_irq_tri;
    int oe_base;
    i_host.access(1'b1, ADDR_MASK1, 8'h01, q);
    @(posedge clk_sys);
    #1 s1_set = 8'h01;
    @(posedge clk_sys);
    #1 s1_set = 8'h00;
    repeat (3) @(posedge clk_sys);
    chk({7'h00, int_oe}, 8'h01);
    chk({7'h00, int_out}, 8'h00);
    i_host.access(1'b0, ADDR_STATUS1, 8'h00, q);
    chk(q, 8'h01);
    #1 tri_st = 1'b1;
    oe_base = oe_cnt;
    i_host.access(1'b0, ADDR_STATUS1, 8'h00, q);
    chk(8'(oe_cnt - oe_base), 8'h00);
    chk({7'h00, int_oe}, 8'h00);
    #1 tri_st = 1'b0;
    repeat (4) @(posedge clk_sys);
    chk({7'h00, int_oe}, 8'h01);
    i_host.access(1'b1, ADDR_STATUS1, 8'h01, q);
    chk({7'h00, int_oe}, 8'h00);
    i_host.access(1'b1, ADDR_MASK2, 8'h80, q);
    @(posedge clk_sys);
    #1 s2_set = 8'h80;
    @(posedge clk_sys);
    #1 s2_set = 8'h00;
    repeat (3) @(posedge clk_sys);
    chk({7'h00, int_oe}, 8'h01);
    i_host.access(1'b0, ADDR_STATUS2, 8'h00, q);
    chk(q, 8'h80);
    i_host.access(1'b1, ADDR_STATUS2, 8'h80, q);
    chk({7'h00, int_oe}, 8'h00);
  endtask : t_irq_tri

  task automatic t_rx_dead;
    #1 rx_run = 1'b0;
    repeat (40) @(posedge clk_sys);
    i_host.access(1'b1, 8'h05, 8'h11, q);
    #1 rx_run = 1'b1;
    repeat (10) @(posedge clk_sys);
    i_host.access(1'b0, 8'h05, 8'h00, q);
    chk(q, 8'hc3);
    i_host.access(1'b1, 8'h05, 8'h22, q);
    i_host.access(1'b0, 8'h05, 8'h00, q);
    chk(q, 8'h22);
  endtask : t_rx_dead

  // ==========================================================================
  // Main sequence and watchdog
  initial
  begin
    repeat (12) @(posedge clk_sys);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    t_sep_rw();
    t_modes();
    t_cs();
    t_irq_tri();
    t_rx_dead();
    close_out();
  end

  initial
  begin
    #500us;
    mismatches++;
    close_out();
  end

endmodule : test_e1p_port
